// ===== logic/ksw_consts.svh
`ifndef KSW_CONSTS_SVH
`define KSW_CONSTS_SVH
// register byte offsets
`define KSW_CTRL_OFS 12'h000
`define KSW_STAT_OFS 12'h004
`define KSW_FAULT_OFS 12'h008
// control field positions
`define KSW_CTRL_RUN 0
`define KSW_CTRL_STOP 1
`define KSW_CTRL_AUTO 2
`define KSW_AUTO_RST 1'b0
// blink timing
`define KSW_CLK_MHZ 250
`define KSW_BLINK_MS 250
`define KSW_PAUSE_PHASES 4
`define KSW_FAULT_CLASSES 7
`endif

// ===== logic/ksw_pkg.sv
package ksw_pkg;
  // power-up sequence, gray along the path
  typedef enum logic [1:0] {
    KSW_DIAG = 2'b00,
    KSW_LOAD = 2'b01,
    KSW_OPER = 2'b11
  } ksw_state_t;
  // selector: top / middle / bottom
  typedef enum logic [1:0] {
    KSW_SEL_TOP = 2'b00,
    KSW_SEL_MID = 2'b01,
    KSW_SEL_BOT = 2'b10
  } ksw_sel_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ksw_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ksw_apb_rsp_t;
  typedef struct packed {
    logic ready;
    logic run;
    logic ser1;
    logic ser2;
    logic net;
    logic memPrt;
    logic bat;
    logic err;
  } ksw_led_t;
endpackage : ksw_pkg

// ===== logic/ksw_mode_leds.sv
// Function
// - protected power-up: no copy, warm restart
// - unprotected power-up: copy image, cold restart
// - slide to protect-off: accept edits, start
// - key to start: accept edits, start
// - ready lamp after diagnostics pass
// - run lamp steady running, else blinks codes
// - activity lamp per serial and network port
// - amber lamp while write protected
// - red lamp when battery low
// - red lamp on network error
// - ram sizing, run output, stack: two
// - backplane bus faults: three blinks
// - communication faults: four blinks
// - ram address five, ram data six
// - executive seven, kernel or flash eight
// - port1 full modem, port2 rts/cts only
// - protect changes act immediately
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`include "ksw_consts.svh"
module ksw_mode_leds
  import ksw_pkg::*;
#(
  // cycles per blink phase; large, so a bench may shorten it
  parameter int unsigned BLINK_PHASE_CYC = `KSW_BLINK_MS * 1000 * `KSW_CLK_MHZ
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire ksw_apb_req_t apbReq,
  output ksw_apb_rsp_t apbRsp,
  input wire ksw_sel_t selPos, // selector position
  input wire logic keyVariant, // 1 key switch, 0 slide switch
  input wire logic diagDone,
  input wire logic diagPass,
  input wire logic copyDone, // image copy finished
  output logic copyReq,
  output logic coldStart,
  output logic warmStart,
  output logic ctrlRun,
  input wire logic editReq,
  output logic editAck,
  output logic editNak,
  output logic editDiscard,
  input wire logic [2:0] portAct, // ser1, ser2, network
  input wire logic batLow,
  input wire logic netErr,
  input wire logic [`KSW_FAULT_CLASSES-1:0] faultIn, // bit i: i+2 blinks
  input wire logic kernelMode,
  input wire logic [1:0] txReq,
  output logic [1:0] txGo,
  output logic ser1Rts,
  output logic ser1Dtr,
  input wire logic ser1Cts,
  input wire logic ser1Dsr,
  input wire logic ser1Cd,
  output logic ser2Rts,
  input wire logic ser2Cts,
  output ksw_led_t leds
);

  ////////////////////////////////////////////////////////////////////
  // state
  ksw_state_t state_ff, nxt_state;
  ksw_sel_t selPrev_ff;
  logic run_ff, nxt_run; // controller running
  logic edit_ff, nxt_edit; // terminal edits accepted
  logic ready_ff; // diagnostics passed
  logic auto_ff; // warm restart resumes running
  logic cold_ff, warm_ff, discard_ff;
  logic ack_ff, nak_ff;
  logic [`KSW_FAULT_CLASSES-1:0] fault_ff; // latched fatal classes
  logic [31:0] prdata_ff;
  ksw_led_t leds_ff;

  ////////////////////////////////////////////////////////////////////
  // selector decode
  wire isProt = (selPos != KSW_SEL_BOT);
  wire selMoved = (selPos != selPrev_ff);
  wire oper = (state_ff == KSW_OPER);

  ////////////////////////////////////////////////////////////////////
  // apb decode
  wire apbSetup = apbReq.psel & ~apbReq.penable;
  wire apbAcc = apbReq.psel & apbReq.penable;
  wire hitCtrl = (apbReq.paddr == `KSW_CTRL_OFS);
  wire hitStat = (apbReq.paddr == `KSW_STAT_OFS);
  wire hitFault = (apbReq.paddr == `KSW_FAULT_OFS);
  wire hitAny = hitCtrl | hitStat | hitFault;
  wire ctrlWr = apbAcc & apbReq.pwrite & hitCtrl;
  // software start/stop only honoured while unprotected
  wire swRun = ctrlWr & apbReq.pwdata[`KSW_CTRL_RUN] & ~isProt;
  wire swStop = ctrlWr & apbReq.pwdata[`KSW_CTRL_STOP] & ~isProt;
  wire [31:0] statWord = {24'h000000, isProt, ready_ff, edit_ff,
    run_ff, kernelMode, state_ff, 1'b0};
  wire [31:0] rdMux = hitCtrl ? {29'h00000000, auto_ff, 2'b00} :
    hitStat ? statWord :
    hitFault ? {25'h0000000, fault_ff} : 32'h00000000;

  // zero-wait slave; read data captured in the setup cycle
  assign apbRsp.pready = 1'b1;
  assign apbRsp.pslverr = apbAcc & ~hitAny;
  assign apbRsp.prdata = prdata_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_ff <= 32'h00000000;
      auto_ff <= `KSW_AUTO_RST;
    end else if (clkEn) begin
      if (apbSetup && !apbReq.pwrite) begin
        prdata_ff <= rdMux;
      end
      if (ctrlWr) begin
        auto_ff <= apbReq.pwdata[`KSW_CTRL_AUTO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // power-up sequence and selector transitions
  always_comb begin
    nxt_state = state_ff;
    nxt_run = run_ff;
    nxt_edit = edit_ff;
    unique case (state_ff)
      KSW_DIAG: begin
        // hold here if diagnostics fail
        if (diagDone && diagPass) begin
          nxt_state = KSW_LOAD;
        end
      end
      KSW_LOAD: begin
        if (isProt) begin
          nxt_state = KSW_OPER;
          nxt_run = auto_ff & (keyVariant ? selPos != KSW_SEL_TOP : 1'b1);
          nxt_edit = 1'b0;
        end else if (copyDone) begin
          nxt_state = KSW_OPER;
          nxt_run = 1'b1;
          nxt_edit = 1'b1;
        end
      end
      KSW_OPER: begin
        if (selMoved) begin
          unique case (selPos)
            KSW_SEL_BOT: begin
              nxt_edit = 1'b1;
              nxt_run = 1'b1;
            end
            KSW_SEL_MID: begin
              nxt_edit = 1'b0;
            end
            default: begin
              nxt_edit = 1'b0;
              if (keyVariant) begin
                nxt_run = 1'b0;
              end
            end
          endcase
        end else if (swRun) begin
          nxt_run = 1'b1;
        end else if (swStop) begin
          nxt_run = 1'b0;
        end
      end
      default: nxt_state = KSW_DIAG;
    endcase
  end

  // copy request held through the load state when unprotected
  assign copyReq = (state_ff == KSW_LOAD) & ~isProt;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= KSW_DIAG;
      selPrev_ff <= KSW_SEL_TOP;
      run_ff <= 1'b0;
      edit_ff <= 1'b0;
      ready_ff <= 1'b0;
      cold_ff <= 1'b0;
      warm_ff <= 1'b0;
      discard_ff <= 1'b0;
    end else if (clkEn) begin
      state_ff <= nxt_state;
      selPrev_ff <= selPos;
      run_ff <= nxt_run;
      edit_ff <= nxt_edit;
      ready_ff <= ready_ff | (diagDone & diagPass);
      cold_ff <= (state_ff == KSW_LOAD) & ~isProt & copyDone;
      warm_ff <= (state_ff == KSW_LOAD) & isProt;
      // key to stop voids pending edits
      discard_ff <= oper & selMoved & keyVariant & (selPos == KSW_SEL_TOP);
    end
  end

  assign coldStart = cold_ff;
  assign warmStart = warm_ff;
  assign ctrlRun = run_ff;
  assign editDiscard = discard_ff;

  ////////////////////////////////////////////////////////////////////
  // terminal edit answers; protection is read live, not from edit_ff
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
      nak_ff <= 1'b0;
    end else if (clkEn) begin
      ack_ff <= editReq & oper & edit_ff & ~isProt;
      nak_ff <= editReq & ~(oper & edit_ff & ~isProt);
    end
  end

  assign editAck = ack_ff;
  assign editNak = nak_ff;

  ////////////////////////////////////////////////////////////////////
  // serial handshakes: port1 full modem, port2 direct link only
  assign ser1Rts = txReq[0];
  assign ser1Dtr = ready_ff;
  assign ser2Rts = txReq[1];
  assign txGo[0] = txReq[0] & ser1Cts & ser1Dsr & ser1Cd;
  assign txGo[1] = txReq[1] & ser2Cts;

  ////////////////////////////////////////////////////////////////////
  // fatal fault latch, one flop per class
  genvar gi;
  generate
    for (gi = 0; gi < `KSW_FAULT_CLASSES; gi++) begin : g_fault
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          fault_ff[gi] <= 1'b0;
        end else if (clkEn && faultIn[gi]) begin
          fault_ff[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // lowest class wins: blinks = index + 2
  logic [3:0] blinkTarget;
  always_comb begin
    blinkTarget = 4'h0;
    for (int i = `KSW_FAULT_CLASSES - 1; i >= 0; i--) begin
      if (fault_ff[i]) begin
        blinkTarget = 4'(i + 2);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // blink engine: on/off phases, then a longer pause
  localparam int unsigned PW = $clog2(BLINK_PHASE_CYC + 1);
  logic [PW-1:0] phase_ff;
  logic lit_ff; // lamp state within a group
  logic [3:0] count_ff; // blinks shown in this group
  logic [2:0] pause_ff; // pause phases left
  wire phaseEnd = (phase_ff == PW'(BLINK_PHASE_CYC - 1));
  wire blinking = kernelMode | (blinkTarget != 4'h0);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff <= '0;
      lit_ff <= 1'b0;
      count_ff <= 4'h0;
      pause_ff <= 3'h0;
    end else if (clkEn) begin
      phase_ff <= (phaseEnd || !blinking) ? '0 : phase_ff + 1'b1;
      if (!blinking) begin
        lit_ff <= 1'b0;
        count_ff <= 4'h0;
        pause_ff <= 3'h0;
      end else if (phaseEnd) begin
        if (kernelMode) begin
          lit_ff <= ~lit_ff;
        end else if (pause_ff != 3'h0) begin
          pause_ff <= pause_ff - 1'b1;
        end else if (lit_ff) begin
          lit_ff <= 1'b0;
          // a class found mid-group may lower the target below the count
          if (count_ff + 1'b1 >= blinkTarget) begin
            count_ff <= 4'h0;
            pause_ff <= 3'(`KSW_PAUSE_PHASES);
          end else begin
            count_ff <= count_ff + 1'b1;
          end
        end else begin
          lit_ff <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // lamp registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      leds_ff <= '0;
    end else if (clkEn) begin
      leds_ff.ready <= ready_ff;
      leds_ff.run <= blinking ? lit_ff : (run_ff & oper);
      leds_ff.ser1 <= portAct[0];
      leds_ff.ser2 <= portAct[1];
      leds_ff.net <= portAct[2];
      leds_ff.memPrt <= isProt;
      leds_ff.bat <= batLow;
      leds_ff.err <= netErr;
    end
  end

  assign leds = leds_ff;

endmodule : ksw_mode_leds

// ===== dv/ksw_mode_leds_properties.sv
module ksw_mode_leds_properties
  import ksw_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire ksw_sel_t selPos,
  input wire logic diagDone,
  input wire logic diagPass,
  input wire logic copyDone,
  input wire logic copyReq,
  input wire logic coldStart,
  input wire logic warmStart,
  input wire logic editReq,
  input wire logic editAck,
  input wire logic [2:0] portAct,
  input wire logic batLow,
  input wire logic netErr,
  input wire logic [1:0] txReq,
  input wire logic [1:0] txGo,
  input wire logic ser1Cts,
  input wire logic ser1Dsr,
  input wire logic ser1Cd,
  input wire logic ser2Cts,
  input wire logic ser2Rts,
  input wire ksw_led_t leds
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic passSeen_ff; // diagnostics passed since reset
  // remembers a passing diagnostic, so the lamp may lag it freely
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) passSeen_ff <= 1'b0;
    else if (clkEn && diagDone && diagPass) passSeen_ff <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  chk_ready_after_diag: assert property (leds.ready |-> passSeen_ff)
    else $error("ready lamp lit without passed diagnostics");
  chk_prot_lamp: assert property (clkEn |=> leds.memPrt == $past(selPos != KSW_SEL_BOT))
    else $error("protect lamp does not follow selector");
  chk_port_lamps: assert property (clkEn |=> {leds.ser1, leds.ser2, leds.net} ==
    $past({portAct[0], portAct[1], portAct[2]})) else $error("port lamp mismatch");
  chk_alarm_lamps: assert property (clkEn |=> {leds.bat, leds.err} == $past({batLow, netErr}))
    else $error("battery or network error lamp mismatch");
  chk_modem_gate: assert property (ser2Rts == txReq[1] &&
    txGo == {txReq[1] & ser2Cts, txReq[0] & ser1Cts & ser1Dsr & ser1Cd})
    else $error("transmit gating mismatch");
  chk_cold_copy: assert property (coldStart |-> $past(copyDone) && $past(copyReq))
    else $error("cold start without finished copy");
  chk_warm_prot: assert property (warmStart |-> !coldStart && $past(selPos) != KSW_SEL_BOT)
    else $error("warm start while unprotected");
  chk_edit_gate: assert property (editAck |-> $past(editReq) && !$past(leds.memPrt))
    else $error("edit accepted while protected");
  cov_warm: cover property (warmStart);
  cov_cold: cover property (coldStart);
  cov_ack: cover property (editAck);
endmodule : ksw_mode_leds_properties

bind ksw_mode_leds ksw_mode_leds_properties u_ksw_mode_leds_properties (.clk, .reset_n,
  .clkEn, .selPos, .diagDone, .diagPass, .copyDone, .copyReq, .coldStart, .warmStart,
  .editReq, .editAck, .portAct, .batLow, .netErr, .txReq, .txGo, .ser1Cts, .ser1Dsr,
  .ser1Cd, .ser2Cts, .ser2Rts, .leds);

// ===== dv/ksw_panel_model.sv
module ksw_panel_model
  import ksw_pkg::*;
(
  input wire logic clk,
  input wire logic keyVariant,
  input wire ksw_sel_t posCmd,
  output ksw_sel_t selPos = KSW_SEL_TOP
);
  timeunit 1ns;
  timeprecision 1ps;
  // operator turns the selector; a slide is never parked in the middle
  always @(posedge clk) begin
    if (keyVariant || posCmd != KSW_SEL_MID) selPos <= posCmd;
  end
endmodule : ksw_panel_model

// ===== dv/keyswitch_mode_and_status_leds_tb.sv
module keyswitch_mode_and_status_leds_tb
  import ksw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BP = 4; // shortened blink phase
  logic clk = 1'b0, reset_n = 1'b0, keyVariant = 1'b0, diagOk = 1'b0, copyDone = 1'b0;
  logic editReq = 1'b0, batLow = 1'b0, netErr = 1'b0, prevRun, err;
  logic clkEn = 1'b1, kernelMode = 1'b0; // freeze and kernel-mode stimulus
  logic ser1Cts = 1'b0, ser1Dsr = 1'b0, ser1Cd = 1'b0, ser2Cts = 1'b0;
  logic [2:0] portAct = '0;
  logic [1:0] txReq = '0, txGo;
  logic [6:0] faultIn = '0;
  logic copyReq, coldStart, warmStart, ctrlRun, editAck, editNak, editDiscard;
  logic ser1Rts, ser1Dtr, ser2Rts;
  logic [31:0] rd;
  ksw_sel_t posCmd = KSW_SEL_TOP, selPos;
  ksw_apb_req_t req = '0;
  ksw_apb_rsp_t rsp;
  ksw_led_t leds;
  int n_mismatch = 0, num_checks = 0, n;
  wire logic [4:0] ev = {editDiscard, copyReq, ctrlRun, coldStart, warmStart};
  always #2 clk = ~clk;
  ksw_mode_leds #(.BLINK_PHASE_CYC(BP)) u_ksw_mode_leds (.clk, .reset_n, .clkEn,
    .apbReq(req), .apbRsp(rsp), .selPos, .keyVariant, .diagDone(diagOk), .diagPass(diagOk),
    .copyDone, .copyReq, .coldStart, .warmStart, .ctrlRun, .editReq, .editAck, .editNak,
    .editDiscard, .portAct, .batLow, .netErr, .faultIn, .kernelMode, .txReq, .txGo,
    .ser1Rts, .ser1Dtr, .ser1Cts, .ser1Dsr, .ser1Cd, .ser2Rts, .ser2Cts, .leds);
  ksw_panel_model u_ksw_panel_model (.clk, .keyVariant, .posCmd, .selPos);
  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk
  // every task starts and ends at a rising edge
  task automatic waitBit(input int b, input logic v);
    int k;
    for (k = 0; k < 400; k++) begin
      @(posedge clk);
      if (ev[b] === v) break;
    end
    if (k == 400) begin
      chk("event wait", 32'(v), 32'(~v));
      report_and_stop();
    end
  endtask : waitBit
  // apb master: hold setup and access until pready, then release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk);
      if (rsp.pready === 1'b1) break;
    end
    if (k == 16) begin
      chk("pready wait", 32'h1, 32'h0);
      report_and_stop();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask : apb
  task automatic edit(input logic [1:0] e);
    editReq <= 1'b1;
    @(posedge clk);
    editReq <= 1'b0;
    @(posedge clk);
    chk("edit ack nak", e, {editAck, editNak});
  endtask : edit
  // rising edges of the run lamp over a window of cycles, into n
  task automatic countRuns(input int cyc);
    n = 0;
    prevRun = leds.run;
    repeat (cyc) begin
      @(posedge clk);
      if (leds.run && !prevRun) n++;
      prevRun = leds.run;
    end
  endtask : countRuns
  task automatic powerUp(input logic kv, input ksw_sel_t p);
    reset_n <= 1'b0;
    diagOk <= 1'b0;
    faultIn <= '0;
    keyVariant <= kv;
    posCmd <= p;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    diagOk <= 1'b1;
  endtask : powerUp
  ////////////////////////////////////////////////////////////////
  initial begin
    @(posedge clk);
    powerUp(1'b0, KSW_SEL_TOP);
    waitBit(0, 1'b1);
    repeat (2) @(posedge clk);
    apb(1'b0, 12'h004, '0);
    chk("status", 32'h0000_00c6, rd);
    chk("ready lamp dtr", 2'b11, {leds.ready, ser1Dtr});
    edit(2'b01);
    posCmd <= KSW_SEL_BOT;
    waitBit(2, 1'b1);
    edit(2'b10);
    chk("run lamp", 1, leds.run);
    chk("protect lamp", 0, leds.memPrt);
    // slide back to protect-on: run kept, edits refused
    posCmd <= KSW_SEL_TOP;
    repeat (4) @(posedge clk);
    chk("slide protect", 2'b11, {ctrlRun, leds.memPrt});
    edit(2'b01);
    posCmd <= KSW_SEL_BOT;
    repeat (4) @(posedge clk);
    apb(1'b1, 12'h000, 32'h4);
    apb(1'b0, 12'h000, '0);
    chk("ctrl autorun", 32'h4, rd);
    apb(1'b0, 12'h00c, '0);
    chk("unmapped error", 32'h1, 32'(err));
    chk("unmapped rdata", 32'h0, rd);
    for (int i = 0; i < 3; i++) begin
      portAct <= 3'b001 << i;
      repeat (2) @(posedge clk);
      chk("port lamps", {i == 0, i == 1, i == 2}, {leds.ser1, leds.ser2, leds.net});
    end
    // enable low: lamps must keep the last port pattern
    clkEn <= 1'b0;
    portAct <= 3'b001;
    repeat (3) @(posedge clk);
    chk("frozen lamps", 3'b001, {leds.ser1, leds.ser2, leds.net});
    clkEn <= 1'b1;
    batLow <= 1'b1;
    netErr <= 1'b1;
    repeat (2) @(posedge clk);
    chk("alarm lamps", 2'b11, {leds.bat, leds.err});
    // every handshake combination, one per cycle
    for (int v = 0; v < 64; v++) begin
      {txReq, ser1Cts, ser1Dsr, ser1Cd, ser2Cts} <= v[5:0];
      @(posedge clk);
      chk("modem gates", {v[5] & v[0], v[4] & v[3] & v[2] & v[1]}, txGo);
      chk("rts", v[5:4], {ser2Rts, ser1Rts});
    end
    // new lowest class each pass; window of two whole groups
    for (int i = 6; i >= 0; i--) begin
      faultIn[i] <= 1'b1;
      repeat (200) @(posedge clk);
      countRuns((2 * (i + 2) + 4) * BP * 2);
      chk("blinks", 2 * (i + 2), n);
    end
    // kernel mode overrides the code: one blink per two phases
    kernelMode <= 1'b1;
    repeat (40) @(posedge clk);
    countRuns(16 * BP);
    chk("kernel blinks", 8, n);
    kernelMode <= 1'b0;
    apb(1'b0, 12'h008, '0);
    chk("fault latch", 32'h7f, rd);
    powerUp(1'b1, KSW_SEL_BOT);
    waitBit(3, 1'b1);
    copyDone <= 1'b1;
    @(posedge clk);
    copyDone <= 1'b0;
    waitBit(1, 1'b1);
    waitBit(2, 1'b1);
    posCmd <= KSW_SEL_MID;
    repeat (4) @(posedge clk);
    chk("run kept", 1, ctrlRun);
    edit(2'b01);
    posCmd <= KSW_SEL_TOP;
    waitBit(4, 1'b1);
    waitBit(2, 1'b0);
    posCmd <= KSW_SEL_BOT;
    waitBit(2, 1'b1);
    edit(2'b10);
    report_and_stop();
  end
endmodule : keyswitch_mode_and_status_leds_tb
